// file: apc_axis_capture.v
// Purpose: position capture with window, retarget and linked start for one axis
// Assumes: registration inputs synchronous to clk; AXI4-Lite register access
// Notes: two independent latches; done flags read as 0 or -1
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "apc_defs.vh"

module apc_axis_capture #(
  parameter POS_W = 32
) (
  input wire clk,
  input wire sys_rst,
  input wire [POS_W-1:0] axisPosition,
  input wire servoTick,
  input wire regInA,
  input wire regInB,
  output reg [POS_W-1:0] moveTarget,
  output wire moveActive,
  output reg linkedStart,
  output wire irq,
  input wire [`APC_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`APC_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // window test shared by both channels
  function winPass;
    input [1:0] mode;
    input [POS_W-1:0] pos;
    input [POS_W-1:0] openP;
    input [POS_W-1:0] closeP;
    begin
      case (mode)
        `APC_WIN_INCL: winPass = !($signed(pos) < $signed(openP)) && !($signed(pos) > $signed(closeP));
        `APC_WIN_EXCL: winPass = !($signed(pos) > $signed(openP)) && !($signed(pos) < $signed(closeP));
        default: winPass = 1'b1;
      endcase
    end
  endfunction

  function [31:0] mergeStrb;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      mergeStrb = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          mergeStrb[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // bus write path
  reg [`APC_ADDR_W-1:0] awAddr_ff;
  reg awHave_ff;
  reg [31:0] wData_ff;
  reg [3:0] wStrb_ff;
  reg wHave_ff;
  wire wrFire = awHave_ff && wHave_ff && !s_axi_bvalid;
  assign s_axi_awready = !awHave_ff && !s_axi_bvalid;
  assign s_axi_wready = !wHave_ff && !s_axi_bvalid;

  reg [POS_W-1:0] openPos_ff;
  reg [POS_W-1:0] closePos_ff;
  reg [POS_W-1:0] afterDist_ff;
  reg [`APC_IRQ_W-1:0] irqStat_ff;
  reg [`APC_IRQ_W-1:0] irqMask_ff;
  reg [1:0] winMode_ff;
  reg fallA_ff;
  reg fallB_ff;
  reg retargetEn_ff;
  reg linkArm_ff;
  reg moving_ff;

  wire isCtrl = wrFire && awAddr_ff == `APC_REG_CTRL;
  wire armA = isCtrl && wData_ff[`APC_CTL_ARMA];
  wire armB = isCtrl && wData_ff[`APC_CTL_ARMB];
  wire mapped = awAddr_ff == `APC_REG_CTRL || awAddr_ff == `APC_REG_OPEN || awAddr_ff == `APC_REG_CLOSE ||
    awAddr_ff == `APC_REG_IRQST || awAddr_ff == `APC_REG_IRQMSK || awAddr_ff == `APC_REG_TARGET ||
    awAddr_ff == `APC_REG_AFTER;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awAddr_ff <= {`APC_ADDR_W{1'b0}};
      awHave_ff <= 1'b0;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
      wHave_ff <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `APC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_ff <= s_axi_awaddr;
        awHave_ff <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
        wHave_ff <= 1'b1;
      end
      if (wrFire) begin
        awHave_ff <= 1'b0;
        wHave_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped ? `APC_RESP_OKAY : `APC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // two latch channels
  reg armedA_ff;
  reg armedB_ff;
  reg doneA_ff;
  reg doneB_ff;
  reg prevA_ff;
  reg prevB_ff;
  reg [POS_W-1:0] rawA_ff;
  reg [POS_W-1:0] rawB_ff;
  reg pendA_ff;
  reg pendB_ff;
  reg [POS_W-1:0] posA_ff;
  reg [POS_W-1:0] posB_ff;

  wire edgeA = fallA_ff ? (prevA_ff && !regInA) : (!prevA_ff && regInA);
  wire edgeB = fallB_ff ? (prevB_ff && !regInB) : (!prevB_ff && regInB);
  wire hitA = edgeA && armedA_ff && !pendA_ff;
  wire hitB = edgeB && armedB_ff && !pendB_ff;
  // judged on the servo tick after the latch
  wire judgeA = pendA_ff && servoTick;
  wire judgeB = pendB_ff && servoTick;
  wire passA = winPass(winMode_ff, rawA_ff, openPos_ff, closePos_ff);
  wire passB = winPass(winMode_ff, rawB_ff, openPos_ff, closePos_ff);
  wire acceptA = judgeA && passA;
  wire acceptB = judgeB && passB;
  wire rejectEv = (judgeA && !passA) || (judgeB && !passB);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prevA_ff <= 1'b0;
      prevB_ff <= 1'b0;
      armedA_ff <= 1'b0;
      armedB_ff <= 1'b0;
      doneA_ff <= 1'b0;
      doneB_ff <= 1'b0;
      pendA_ff <= 1'b0;
      pendB_ff <= 1'b0;
      rawA_ff <= {POS_W{1'b0}};
      rawB_ff <= {POS_W{1'b0}};
      posA_ff <= {POS_W{1'b0}};
      posB_ff <= {POS_W{1'b0}};
    end else begin
      prevA_ff <= regInA;
      prevB_ff <= regInB;
      if (hitA) begin
        rawA_ff <= axisPosition;
        pendA_ff <= 1'b1;
        armedA_ff <= 1'b0;
      end
      if (judgeA) begin
        pendA_ff <= 1'b0;
        if (passA) begin
          doneA_ff <= 1'b1;
          posA_ff <= rawA_ff;
        end else begin
          armedA_ff <= 1'b1;
        end
      end
      // arm clears done and arms latch
      if (armA) begin
        doneA_ff <= 1'b0;
        armedA_ff <= 1'b1;
        pendA_ff <= 1'b0;
      end
      if (hitB) begin
        rawB_ff <= axisPosition;
        pendB_ff <= 1'b1;
        armedB_ff <= 1'b0;
      end
      if (judgeB) begin
        pendB_ff <= 1'b0;
        if (passB) begin
          doneB_ff <= 1'b1;
          posB_ff <= rawB_ff;
        end else begin
          armedB_ff <= 1'b1;
        end
      end
      if (armB) begin
        doneB_ff <= 1'b0;
        armedB_ff <= 1'b1;
        pendB_ff <= 1'b0;
      end
    end
  end

  // config, move, link, interrupts
  wire [`APC_IRQ_W-1:0] irqEvents = {hitA && linkArm_ff, rejectEv, acceptB, acceptA};
  assign irq = |(irqStat_ff & irqMask_ff);
  assign moveActive = moving_ff;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      openPos_ff <= {POS_W{1'b0}};
      closePos_ff <= {POS_W{1'b0}};
      afterDist_ff <= {POS_W{1'b0}};
      irqStat_ff <= {`APC_IRQ_W{1'b0}};
      irqMask_ff <= {`APC_IRQ_W{1'b0}};
      winMode_ff <= `APC_WIN_OFF;
      fallA_ff <= 1'b0;
      fallB_ff <= 1'b0;
      retargetEn_ff <= 1'b0;
      linkArm_ff <= 1'b0;
      moving_ff <= 1'b0;
      moveTarget <= {POS_W{1'b0}};
      linkedStart <= 1'b0;
    end else begin
      linkedStart <= 1'b0;
      if (wrFire && awAddr_ff == `APC_REG_OPEN) begin
        openPos_ff <= mergeStrb(openPos_ff, wData_ff, wStrb_ff);
      end
      if (wrFire && awAddr_ff == `APC_REG_CLOSE) begin
        closePos_ff <= mergeStrb(closePos_ff, wData_ff, wStrb_ff);
      end
      if (wrFire && awAddr_ff == `APC_REG_AFTER) begin
        afterDist_ff <= mergeStrb(afterDist_ff, wData_ff, wStrb_ff);
      end
      if (wrFire && awAddr_ff == `APC_REG_TARGET) begin
        moveTarget <= mergeStrb(moveTarget, wData_ff, wStrb_ff);
      end
      if (wrFire && awAddr_ff == `APC_REG_IRQMSK) begin
        irqMask_ff <= wData_ff[`APC_IRQ_W-1:0];
      end
      // set wins over write-one-to-clear
      if (wrFire && awAddr_ff == `APC_REG_IRQST) begin
        irqStat_ff <= (irqStat_ff & ~wData_ff[`APC_IRQ_W-1:0]) | irqEvents;
      end else begin
        irqStat_ff <= irqStat_ff | irqEvents;
      end
      if (isCtrl) begin
        winMode_ff <= wData_ff[`APC_CTL_WINHI:`APC_CTL_WINLO];
        fallA_ff <= wData_ff[`APC_CTL_FALLA];
        fallB_ff <= wData_ff[`APC_CTL_FALLB];
        retargetEn_ff <= wData_ff[`APC_CTL_RETGT];
        linkArm_ff <= wData_ff[`APC_CTL_LINK];
        if (wData_ff[`APC_CTL_MOVE]) begin
          moving_ff <= 1'b1;
        end
      end else begin
        // slave starts on master edge itself
        if (linkArm_ff && hitA) begin
          linkedStart <= 1'b1;
          linkArm_ff <= 1'b0;
        end
        if (acceptA && retargetEn_ff && moving_ff) begin
          moveTarget <= rawA_ff + afterDist_ff;
          retargetEn_ff <= 1'b0;
        end
        // move ends when the axis reaches its target
        if (moving_ff && axisPosition == moveTarget) begin
          moving_ff <= 1'b0;
        end
      end
    end
  end

  // bus read path
  assign s_axi_arready = !s_axi_rvalid;
  reg [31:0] rdMux;
  reg rdOk;
  always @* begin
    rdMux = 32'h00000000;
    rdOk = 1'b1;
    case (s_axi_araddr)
      `APC_REG_CTRL: begin
        rdMux[`APC_CTL_WINHI:`APC_CTL_WINLO] = winMode_ff;
        rdMux[`APC_CTL_FALLA] = fallA_ff;
        rdMux[`APC_CTL_FALLB] = fallB_ff;
        rdMux[`APC_CTL_RETGT] = retargetEn_ff;
        rdMux[`APC_CTL_LINK] = linkArm_ff;
      end
      `APC_REG_STAT: begin
        rdMux[`APC_ST_DONEA] = doneA_ff;
        rdMux[`APC_ST_DONEB] = doneB_ff;
        rdMux[`APC_ST_ARMEDA] = armedA_ff || pendA_ff;
        rdMux[`APC_ST_ARMEDB] = armedB_ff || pendB_ff;
        rdMux[`APC_ST_LINKW] = linkArm_ff;
        rdMux[`APC_ST_MOVING] = moving_ff;
      end
      `APC_REG_OPEN: rdMux = openPos_ff;
      `APC_REG_CLOSE: rdMux = closePos_ff;
      `APC_REG_POSA: rdMux = posA_ff;
      `APC_SECOND_CAPTURED_POSITION: rdMux = posB_ff;
      `APC_REG_IRQST: rdMux[`APC_IRQ_W-1:0] = irqStat_ff;
      `APC_REG_IRQMSK: rdMux[`APC_IRQ_W-1:0] = irqMask_ff;
      `APC_REG_TARGET: rdMux = moveTarget;
      `APC_REG_AFTER: rdMux = afterDist_ff;
      `APC_REG_AXPOS: rdMux = axisPosition;
      // flag words read 0 or -1
      `APC_REG_DONEA: rdMux = doneA_ff ? `APC_DONE_SET : `APC_DONE_CLR;
      `APC_REG_DONEB: rdMux = doneB_ff ? `APC_DONE_SET : `APC_DONE_CLR;
      default: rdOk = 1'b0;
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `APC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdOk ? `APC_RESP_OKAY : `APC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: apc_capture_properties.sv
// Purpose: port-level checks for the axis capture block
// Assumes: one clock, async active-high reset
// Notes: bound to every instance of the design
`timescale 1ns/1ps
`default_nettype none
module apc_capture_properties #(
  parameter POS_W = 32
) (
  input wire clk,
  input wire sys_rst,
  input wire [POS_W-1:0] axisPosition,
  input wire servoTick,
  input wire regInA,
  input wire [POS_W-1:0] moveTarget,
  input wire moveActive,
  input wire linkedStart,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  rdata_held_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved before rready");
  write_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  read_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  link_pulse_a: assert property (linkedStart |=> !linkedStart)
    else $error("linked start longer than one cycle");
  link_edge_a: assert property (linkedStart |-> $past(regInA) != $past(regInA, 2))
    else $error("linked start without input edge");
  move_end_a: assert property ($fell(moveActive) |-> $past(axisPosition == moveTarget))
    else $error("move ended away from target");
  target_cause_a: assert property ($changed(moveTarget) && !$past(servoTick) |-> ##[0:1] s_axi_bvalid)
    else $error("move target changed without cause");
endmodule
bind apc_axis_capture apc_capture_properties #(.POS_W(POS_W)) i_props (.clk, .sys_rst, .axisPosition,
  .servoTick, .regInA, .moveTarget, .moveActive, .linkedStart, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// file: apc_defs.vh
// Purpose: constants for the axis position capture block
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register
// Notes: include once; definitions only
`ifndef APC_DEFS_VH
`define APC_DEFS_VH

`define APC_ADDR_W 8
// register byte offsets
`define APC_REG_CTRL 8'h00
`define APC_REG_STAT 8'h04
`define APC_REG_OPEN 8'h08
`define APC_REG_CLOSE 8'h0C
`define APC_REG_POSA 8'h10
`define APC_SECOND_CAPTURED_POSITION 8'h14
`define APC_REG_IRQST 8'h18
`define APC_REG_IRQMSK 8'h1C
`define APC_REG_TARGET 8'h20
`define APC_REG_AFTER 8'h24
`define APC_REG_AXPOS 8'h28
`define APC_REG_DONEA 8'h2C
`define APC_REG_DONEB 8'h30

// control register fields (writes act as commands)
`define APC_CTL_ARMA 0
`define APC_CTL_ARMB 1
`define APC_CTL_WINLO 2
`define APC_CTL_WINHI 3
`define APC_CTL_FALLA 4
`define APC_CTL_FALLB 5
`define APC_CTL_RETGT 6
`define APC_CTL_LINK 7
`define APC_CTL_MOVE 8

// window modes
`define APC_WIN_OFF 2'h0
`define APC_WIN_INCL 2'h1
`define APC_WIN_EXCL 2'h2

// status bits
`define APC_ST_DONEA 0
`define APC_ST_DONEB 1
`define APC_ST_ARMEDA 2
`define APC_ST_ARMEDB 3
`define APC_ST_LINKW 4
`define APC_ST_MOVING 5

// interrupt bits
`define APC_IRQ_W 4
`define APC_IRQ_CAPA 0
`define APC_IRQ_CAPB 1
`define APC_IRQ_REJ 2
`define APC_IRQ_LINK 3

// done flag encodings: cleared 0, captured all ones (-1)
`define APC_DONE_CLR 32'h00000000
`define APC_DONE_SET 32'hFFFFFFFF

// axi responses
`define APC_RESP_OKAY 2'h0
`define APC_RESP_SLVERR 2'h2

// timing: latch within 0.5 us of the edge
`define APC_CLK_NS 8
`define APC_LATCH_NS 500
`define APC_LATCH_CYC ((`APC_LATCH_NS) / (`APC_CLK_NS))

`endif

// file: apc_sensor_model.sv
// Purpose: registration sensor model for both capture inputs
// Assumes: sensor lines idle low between marks
// Notes: a mark is a rising edge held about four clocks
`timescale 1ns/1ps
`default_nettype none
module apc_reg_sensor (
  input wire logic clk,
  output logic regInA,
  output logic regInB
);
  logic [2:0] holdA_ff = 3'h0;
  logic [2:0] holdB_ff = 3'h0;
  initial begin
    regInA = 1'h0;
    regInB = 1'h0;
  end
  task automatic mark(input int ch);
    if (ch == 0)
      regInA <= 1'h1;
    else
      regInB <= 1'h1;
  endtask
  // long enough to be seen, short enough to re-arm between marks
  always @(posedge clk) begin
    holdA_ff <= regInA ? holdA_ff + 3'h1 : 3'h0;
    holdB_ff <= regInB ? holdB_ff + 3'h1 : 3'h0;
    if (holdA_ff == 3'h3)
      regInA <= 1'h0;
    if (holdB_ff == 3'h3)
      regInB <= 1'h0;
  end
endmodule
`default_nettype wire

// file: axis_position_capture_window_tb.sv
// Purpose: self-checking bench for the axis capture block
// Assumes: 125 MHz clock, registers over AXI4-Lite
// Notes: sensor edges come from the partner model
`timescale 1ns/1ps
`default_nettype none
`include "apc_defs.vh"
module axis_position_capture_window_tb;
  localparam logic [7:0] DONE_A = `APC_REG_DONEA;
  localparam logic [7:0] DONE_B = `APC_REG_DONEB;
  localparam logic [7:0] UNMAPPED = 8'h40;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic servoTick = 1'h0;
  logic [31:0] axisPosition = 32'h0;
  logic [7:0] s_axi_awaddr = 8'h0;
  logic [7:0] s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire regInA, regInB, moveActive, linkedStart, irq;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [31:0] moveTarget, s_axi_rdata;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  int mismatches = 0;
  int nTests = 0;
  logic [31:0] rdv, last;
  // axis held still at each mark, so window bounds are exact
  int wm[7] = '{1, 1, 1, 2, 2, 2, 0};
  int wp[7] = '{999, 1000, 2001, 3001, 1999, 2500, 9};
  bit wa[7] = '{0, 1, 0, 0, 0, 1, 1};
  always #4 clk = ~clk;
  apc_axis_capture #(.POS_W(32)) i_dut (.clk, .sys_rst, .axisPosition, .servoTick, .regInA, .regInB, .moveTarget,
    .moveActive, .linkedStart, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  apc_reg_sensor i_sens (.clk, .regInA, .regInB);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic pa, pw;
    @(posedge clk);
    pa = 1'h1;
    pw = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (pa || pw) begin
      @(posedge clk);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    while (!s_axi_bvalid) @(posedge clk);
    chk("bresp", e, s_axi_bresp);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    while (!s_axi_rvalid) @(posedge clk);
    d = s_axi_rdata;
    chk("rresp", e, s_axi_rresp);
    s_axi_rready <= 1'h0;
  endtask
  task automatic look(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] v;
    rd(a, v, `APC_RESP_OKAY);
    chk(n, e, v);
  endtask
  task automatic hit(input int ch, input logic [31:0] p);
    axisPosition <= p;
    i_sens.mark(ch);
  endtask
  task automatic tick;
    repeat (2) @(posedge clk);
    servoTick <= 1'h1;
    @(posedge clk);
    servoTick <= 1'h0;
    @(posedge clk);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    look(`APC_REG_STAT, 32'h0, "status reset");
    wr(`APC_REG_CTRL, 32'h1, `APC_RESP_OKAY);
    look(DONE_A, `APC_DONE_CLR, "doneA armed");
    hit(0, 32'h64);
    look(DONE_A, `APC_DONE_CLR, "doneA before tick");
    tick;
    look(DONE_A, `APC_DONE_SET, "doneA set");
    look(`APC_REG_POSA, 32'h64, "capA");
    hit(0, 32'hC8);
    tick;
    look(`APC_REG_POSA, 32'h64, "capA after done");
    wr(`APC_REG_CTRL, 32'h1, `APC_RESP_OKAY);
    look(`APC_REG_POSA, 32'h64, "capA rearmed");
    look(`APC_REG_STAT, 32'h4, "status rearmed");
    wr(`APC_REG_CTRL, 32'h3, `APC_RESP_OKAY);
    hit(0, 32'h12C);
    @(posedge clk);
    hit(1, 32'h190);
    tick;
    look(`APC_REG_POSA, 32'h12C, "capA pair");
    look(`APC_SECOND_CAPTURED_POSITION, 32'h190, "capB");
    look(DONE_B, `APC_DONE_SET, "doneB");
    last = 32'h12C;
    for (int i = 0; i < 7; i++) begin
      if (i == 0 || wa[i-1] || wm[i] != wm[i-1]) begin
        wr(`APC_REG_OPEN, (wm[i] == 1) ? 32'h3E8 : 32'hBB8, `APC_RESP_OKAY);
        wr(`APC_REG_CLOSE, 32'h7D0, `APC_RESP_OKAY);
        wr(`APC_REG_CTRL, 32'h1 | 32'(wm[i] << 2), `APC_RESP_OKAY);
      end
      hit(0, wp[i]);
      tick;
      if (wa[i])
        last = wp[i];
      look(`APC_REG_STAT, wa[i] ? 32'h3 : 32'h6, "window status");
      look(`APC_REG_POSA, last, "window capA");
    end
    look(`APC_REG_IRQST, 32'h7, "irq status");
    chk("irq masked", 32'h0, irq);
    wr(`APC_REG_IRQMSK, 32'h4, `APC_RESP_OKAY);
    chk("irq unmasked", 32'h1, irq);
    wr(`APC_REG_IRQST, 32'h4, `APC_RESP_OKAY);
    chk("irq cleared", 32'h0, irq);
    look(`APC_REG_IRQST, 32'h3, "irq after clear");
    wr(`APC_REG_IRQMSK, 32'h0, `APC_RESP_OKAY);
    wr(UNMAPPED, 32'hFFFFFFFF, `APC_RESP_SLVERR);
    rd(UNMAPPED, rdv, `APC_RESP_SLVERR);
    look(`APC_REG_AXPOS, 32'h9, "live position");
    wr(`APC_REG_TARGET, 32'h1000, `APC_RESP_OKAY);
    wr(`APC_REG_AFTER, 32'h50, `APC_RESP_OKAY);
    wr(`APC_REG_CTRL, 32'h141, `APC_RESP_OKAY);
    chk("moving", 32'h1, moveActive);
    hit(0, 32'h200);
    tick;
    chk("retarget", 32'h250, moveTarget);
    axisPosition <= 32'h250;
    repeat (3) @(posedge clk);
    chk("move ended", 32'h0, moveActive);
    // falling-edge mode: the rising mark must not latch
    wr(`APC_REG_CTRL, 32'h11, `APC_RESP_OKAY);
    hit(0, 32'h400);
    tick;
    axisPosition <= 32'h404;
    look(DONE_A, `APC_DONE_CLR, "doneA rise ignored");
    tick;
    look(`APC_REG_POSA, 32'h404, "capA falling");
    wr(`APC_REG_CTRL, 32'h81, `APC_RESP_OKAY);
    hit(0, 32'h300);
    @(posedge clk);
    #1 chk("link start", 32'h1, linkedStart);
    @(posedge clk);
    #1 chk("link single", 32'h0, linkedStart);
    close_out;
  end
endmodule
`default_nettype wire
